//--- common/acc_pkg.sv
// Package for the converter common control register block.
// Assumes an APB slave with 32-bit data; registers hold 16 bits each.
package acc_pkg;
   localparam int          ADDR_W = 12;
   // Register byte addresses.
   localparam logic [11:0] OFS_REF_STATUS = 12'h000;
   localparam logic [11:0] OFS_TRIG_CTRL  = 12'h004;
   localparam logic [11:0] OFS_CLK_EN     = 12'h008;
   localparam logic [11:0] OFS_CONV_ON    = 12'h00C;
   // Field positions in the reference status and sample time register.
   localparam int BIT_BG_READY   = 15;
   localparam int BIT_REF_ERROR  = 14;
   localparam int SAMT_LSB       = 0;
   localparam int SAMT_W         = 10;
   // Field positions in the reference and trigger control register.
   localparam int REFERENCE_SELECT_LSB     = 13;
   localparam int REFERENCE_SELECT_W       = 3;
   localparam int BIT_HOLD       = 12;
   localparam int BIT_HOLD_IE    = 11;
   localparam int BIT_HOLD_DONE  = 10;
   localparam int BIT_MANUAL     = 9;
   localparam int BIT_CH_TRIG    = 8;
   localparam int BIT_LVL_TRIG   = 7;
   localparam int BIT_PULSE_TRIG = 6;
   localparam int CHAN_LSB       = 0;
   localparam int CHAN_W         = 6;
   // Field positions in the clock and core enable register.
   localparam int CSRC_LSB       = 14;
   localparam int CSRC_W         = 2;
   localparam int CDIV_LSB       = 8;
   localparam int CDIV_W         = 6;
   localparam int BIT_SHR_EN     = 7;
   localparam int NUM_DED        = 4;
   // Sample time adds two core clock periods to the field.
   localparam logic [10:0] SAMT_BASE = 11'h002;
   // Reset values.
   localparam logic [15:0] RST_VAL   = 16'h0000;
   localparam logic [2:0]  REFERENCE_SELECT_AV = 3'h0;
   // Converter clock source encodings.
   typedef enum logic [1:0] {
      ACC_SRC_SYS   = 2'b00,
      ACC_SRC_SYSX2 = 2'b01,
      ACC_SRC_RC    = 2'b10,
      ACC_SRC_PLL   = 2'b11
   } acc_src_t;
endpackage : acc_pkg

//--- hdl/acc_regs.sv
// Common control and status registers of a multi-core converter.
// Assumes an APB master on pclk; analog status pins are asynchronous.
//
// What this block does
// - Bit 15 reads the synchronised band gap ready state, read only.
// - Bit 14 sets when band gap drops while converter is on.
// - Ten-bit sample time field; sample time is field plus two.
// - Reference code 000 selects supply rails; other codes unused.
// - While hold bit is set, all new core triggers are blocked.
// - Hold-done flag is set when hold is on and no core busy.
// - Hold-done interrupt pulses on flag rising if enabled.
// - Manual sample bit makes shared core sample the chosen channel.
// - Channel trigger bit gives one trigger, then clears itself.
// - Level common trigger bit gives triggers while it is set.
// - Pulse common trigger bit gives one trigger, then clears itself.
// - Six-bit channel number selects converted and sampled channel.
// - Two-bit clock source: PLL, RC, double system, system clock.
// - Clock divider divides selected source by field plus one.
// - Divided source clock feeds every shared and dedicated core.
// - Shared core enable bit switches the shared core.
// - Four dedicated core enables in bits 3..0; bits 6..4 zero.
`timescale 1ns/1ps
`default_nettype none
module acc_regs
   import acc_pkg::*;
#(
   parameter int CHAN_WIDTH = acc_pkg::CHAN_W
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [acc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      band_gap_ok,
   input  wire logic                      cores_busy,
   output logic                           converter_on,
   output logic      [10:0]               shared_sample_cycles,
   output logic      [2:0]                reference_select,
   output logic                           trigger_hold,
   output logic                           hold_done_irq,
   output logic                           shared_manual_sample,
   output logic                           sw_channel_trigger,
   output logic                           sw_level_common_trigger,
   output logic                           sw_pulse_common_trigger,
   output logic      [CHAN_WIDTH-1:0]     sw_channel_number,
   output logic      [1:0]                conv_clock_source,
   output logic      [5:0]                conv_clock_divider,
   output logic      [6:0]                core_source_div_count,
   output logic                           shared_core_enable,
   output logic      [3:0]                dedicated_core_enable
);
   import acc_pkg::*;

   logic              bg_meta_q;
   logic              bg_sync_q;
   logic              busy_meta_q;
   logic              busy_sync_q;
   logic              on_q;
   logic              ref_err_q;
   logic              hold_done_q;
   logic [SAMT_W-1:0] samt_q;
   logic [2:0]        reference_select_q;
   logic              hold_q;
   logic              hold_ie_q;
   logic              manual_q;
   logic              ch_trig_q;
   logic              lvl_trig_q;
   logic              pulse_trig_q;
   logic [CHAN_WIDTH-1:0] chan_q;
   logic [1:0]        csrc_q;
   logic [5:0]        cdiv_q;
   logic              shr_en_q;
   logic [3:0]        ded_en_q;
   logic              irq_q;
   logic              ready_q;
   logic [31:0]       rdata_q;
   logic              err_q;
   logic              chtrig_out_q;
   logic              lvl_out_q;
   logic              pulse_out_q;
   logic              hold_done_d;
   logic              was_ready_q;
   logic [SAMT_W:0]   samt_cyc_q;
   logic [CDIV_W:0]   div_cnt_q;
   logic              wr_trig;
   logic              wr_clk;
   logic              wr;
   logic              rd;
   logic [15:0]       rd_word;

   // One wait state lets the read word settle in a flop before pready.
   assign wr = psel && penable && !ready_q && pwrite;
   assign rd = psel && penable && !ready_q && !pwrite;
   assign wr_trig = wr && hit(paddr, OFS_TRIG_CTRL);
   assign wr_clk  = wr && hit(paddr, OFS_CLK_EN);

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFS_REF_STATUS) || (a == OFS_TRIG_CTRL) ||
               (a == OFS_CLK_EN) || (a == OFS_CONV_ON);
   endfunction : mapped

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [SAMT_W:0] samt_cycles(
      input logic [SAMT_W-1:0] f);
      samt_cycles = {1'b0, f} + SAMT_BASE;
   endfunction : samt_cycles

   function automatic logic [CDIV_W:0] div_ratio(
      input logic [CDIV_W-1:0] f);
      div_ratio = {1'b0, f} + 7'h01;
   endfunction : div_ratio

   // Asynchronous analog status pins pass two flops before use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bg_meta_q   <= 1'b0;
         bg_sync_q   <= 1'b0;
         busy_meta_q <= 1'b0;
         busy_sync_q <= 1'b0;
      end else begin
         bg_meta_q   <= band_gap_ok;
         bg_sync_q   <= bg_meta_q;
         busy_meta_q <= cores_busy;
         busy_sync_q <= busy_meta_q;
      end
   end

   // Converter-on control, needed to qualify the band gap error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q <= 1'b0;
      end else if (wr && hit(paddr, OFS_CONV_ON)) begin
         on_q <= pwdata[0];
      end
   end

   // Sticky error; only a converter switch-off clears it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_err_q <= 1'b0;
      end else if (on_q && !bg_sync_q && was_ready_q) begin
         ref_err_q <= 1'b1;
      end else if (!on_q) begin
         ref_err_q <= 1'b0;
      end
   end

   // The error needs the band gap to have been ready once while on.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         was_ready_q <= 1'b0;
      end else if (!on_q) begin
         was_ready_q <= 1'b0;
      end else if (bg_sync_q) begin
         was_ready_q <= 1'b1;
      end
   end

   assign hold_done_d = hold_q && !busy_sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_done_q <= 1'b0;
         irq_q       <= 1'b0;
      end else begin
         hold_done_q <= hold_done_d;
         irq_q       <= hold_ie_q && hold_done_d && !hold_done_q;
      end
   end

   // The cycle count is kept in a flop so the output needs no adder.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samt_q     <= RST_VAL[SAMT_W-1:0];
         samt_cyc_q <= SAMT_BASE;
      end else if (wr && hit(paddr, OFS_REF_STATUS)) begin
         samt_q     <= pwdata[SAMT_LSB +: SAMT_W];
         samt_cyc_q <= samt_cycles(pwdata[SAMT_LSB +: SAMT_W]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_select_q <= REFERENCE_SELECT_AV;
      end else if (wr_trig) begin
         reference_select_q <= pwdata[REFERENCE_SELECT_LSB +: REFERENCE_SELECT_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 1'b0;
      end else if (wr_trig) begin
         hold_q <= pwdata[BIT_HOLD];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ie_q <= 1'b0;
      end else if (wr_trig) begin
         hold_ie_q <= pwdata[BIT_HOLD_IE];
      end
   end

   // Hardware never clears this bit; software owns it entirely.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         manual_q <= 1'b0;
      end else if (wr_trig) begin
         manual_q <= pwdata[BIT_MANUAL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_trig_q <= 1'b0;
      end else if (wr_trig) begin
         lvl_trig_q <= pwdata[BIT_LVL_TRIG];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_q <= RST_VAL[CHAN_WIDTH-1:0];
      end else if (wr_trig) begin
         chan_q <= pwdata[CHAN_LSB +: CHAN_WIDTH];
      end
   end

   // Self-clearing trigger bits hold for one cycle after the write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_trig_q    <= 1'b0;
         pulse_trig_q <= 1'b0;
      end else begin
         ch_trig_q    <= wr && hit(paddr, OFS_TRIG_CTRL) &&
                         pwdata[BIT_CH_TRIG];
         pulse_trig_q <= wr && hit(paddr, OFS_TRIG_CTRL) &&
                         pwdata[BIT_PULSE_TRIG];
      end
   end

   // Triggers are gated by the hold bit so that none leak out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chtrig_out_q <= 1'b0;
         lvl_out_q    <= 1'b0;
         pulse_out_q  <= 1'b0;
      end else begin
         chtrig_out_q <= ch_trig_q && !hold_q;
         lvl_out_q    <= lvl_trig_q && !hold_q;
         pulse_out_q  <= pulse_trig_q && !hold_q;
      end
   end

   // Clock source, divider and core enables.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csrc_q <= ACC_SRC_SYS;
      end else if (wr_clk) begin
         csrc_q <= pwdata[CSRC_LSB +: CSRC_W];
      end
   end

   // The ratio is stored beside the field so both change on one edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cdiv_q    <= RST_VAL[CDIV_W-1:0];
         div_cnt_q <= 7'h01;
      end else if (wr_clk) begin
         cdiv_q    <= pwdata[CDIV_LSB +: CDIV_W];
         div_cnt_q <= div_ratio(pwdata[CDIV_LSB +: CDIV_W]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shr_en_q <= 1'b0;
      end else if (wr_clk) begin
         shr_en_q <= pwdata[BIT_SHR_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ded_en_q <= RST_VAL[NUM_DED-1:0];
      end else if (wr_clk) begin
         ded_en_q <= pwdata[NUM_DED-1:0];
      end
   end

   always_comb begin
      rd_word = 16'h0000;
      unique case (1'b1)
         hit(paddr, OFS_REF_STATUS): begin
            rd_word[BIT_BG_READY]  = bg_sync_q;
            rd_word[BIT_REF_ERROR] = ref_err_q;
            rd_word[SAMT_LSB +: SAMT_W] = samt_q;
         end
         hit(paddr, OFS_TRIG_CTRL): begin
            rd_word[REFERENCE_SELECT_LSB +: REFERENCE_SELECT_W] = reference_select_q;
            rd_word[BIT_HOLD]       = hold_q;
            rd_word[BIT_HOLD_IE]    = hold_ie_q;
            rd_word[BIT_HOLD_DONE]  = hold_done_q;
            rd_word[BIT_MANUAL]     = manual_q;
            rd_word[BIT_CH_TRIG]    = ch_trig_q;
            rd_word[BIT_LVL_TRIG]   = lvl_trig_q;
            rd_word[BIT_PULSE_TRIG] = pulse_trig_q;
            rd_word[CHAN_LSB +: CHAN_WIDTH] = chan_q;
         end
         hit(paddr, OFS_CLK_EN): begin
            rd_word[CSRC_LSB +: CSRC_W] = csrc_q;
            rd_word[CDIV_LSB +: CDIV_W] = cdiv_q;
            rd_word[BIT_SHR_EN]         = shr_en_q;
            rd_word[NUM_DED-1:0]        = ded_en_q;
         end
         hit(paddr, OFS_CONV_ON): begin
            rd_word[0] = on_q;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // APB answer: one wait state, error on unmapped addresses.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
         rdata_q <= 32'h00000000;
         err_q   <= 1'b0;
      end else begin
         ready_q <= psel && penable && !ready_q;
         err_q   <= psel && penable && !ready_q && !mapped(paddr);
         // Writes and refused reads return zero, never a stale word.
         if (psel && penable && !ready_q) begin
            rdata_q <= rd ? {16'h0000, rd_word} : 32'h00000000;
         end
      end
   end

   assign prdata                  = rdata_q;
   assign pready                  = ready_q;
   assign pslverr                 = err_q;
   assign converter_on            = on_q;
   // Sample cycles in core clock periods, field plus two.
   assign shared_sample_cycles    = samt_cyc_q;
   assign reference_select        = reference_select_q;
   assign trigger_hold            = hold_q;
   assign hold_done_irq           = irq_q;
   assign shared_manual_sample    = manual_q;
   assign sw_channel_trigger      = chtrig_out_q;
   assign sw_level_common_trigger = lvl_out_q;
   assign sw_pulse_common_trigger = pulse_out_q;
   assign sw_channel_number       = chan_q;
   assign conv_clock_source       = csrc_q;
   assign conv_clock_divider      = cdiv_q;
   // Division ratio seen by every core clock divider downstream.
   assign core_source_div_count   = div_cnt_q;
   assign shared_core_enable      = shr_en_q;
   assign dedicated_core_enable   = ded_en_q;
endmodule : acc_regs
`default_nettype wire

//--- tb/acc_regs_monitor.sv
// Checker for the converter common control registers.
// Sees only the ports of acc_regs and is bound to it below.
`timescale 1ns/1ps
`default_nettype none
module acc_regs_monitor
   import acc_pkg::*;
(
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [acc_pkg::ADDR_W-1:0]  paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic [10:0]                 shared_sample_cycles,
   input wire logic                        trigger_hold,
   input wire logic                        hold_done_irq,
   input wire logic                        sw_channel_trigger,
   input wire logic                        sw_pulse_common_trigger,
   input wire logic [1:0]                  conv_clock_source,
   input wire logic [5:0]                  conv_clock_divider,
   input wire logic [6:0]                  core_source_div_count,
   input wire logic [3:0]                  dedicated_core_enable
);
   wire logic wr_done = psel && penable && pready && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   samt_update_a:
   assert property (wr_done && paddr == OFS_REF_STATUS |=>
      shared_sample_cycles == {1'b0, $past(pwdata[9:0])} + SAMT_BASE)
      else $error("sample time does not follow the written field");
   div_count_a:
   assert property (core_source_div_count == {1'b0, conv_clock_divider} + 7'h01)
      else $error("divider count is not field plus one");
   clk_update_a:
   assert property (wr_done && paddr == OFS_CLK_EN |=>
      conv_clock_source == $past(pwdata[15:14]) &&
      dedicated_core_enable == $past(pwdata[3:0]))
      else $error("clock source or core enables not taken");
   hold_block_a:
   assert property (trigger_hold && $past(trigger_hold) |->
      !sw_channel_trigger && !sw_pulse_common_trigger)
      else $error("trigger issued while held");
   ch_pulse_a:
   assert property (sw_channel_trigger |=> !sw_channel_trigger)
      else $error("channel trigger longer than one cycle");
   pulse_once_a:
   assert property (sw_pulse_common_trigger |=> !sw_pulse_common_trigger)
      else $error("common pulse trigger longer than one cycle");
   ch_fire_a:
   assert property (wr_done && paddr == OFS_TRIG_CTRL && pwdata[BIT_CH_TRIG]
      && !pwdata[BIT_HOLD] && !trigger_hold |-> ##[0:3] sw_channel_trigger)
      else $error("channel trigger write gave no trigger");
   irq_pulse_a:
   assert property (hold_done_irq |-> trigger_hold ##1 !hold_done_irq)
      else $error("hold done interrupt without hold or too long");
   unmapped_a:
   assert property (psel && penable && pready && paddr > OFS_CONV_ON |->
      pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
endmodule : acc_regs_monitor
bind acc_regs acc_regs_monitor u_mon (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .shared_sample_cycles, .trigger_hold, .hold_done_irq, .sw_channel_trigger,
   .sw_pulse_common_trigger, .conv_clock_source, .conv_clock_divider,
   .core_source_div_count, .dedicated_core_enable);
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the converter common control registers.
// Drives APB and the analog status inputs itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v, got;
   logic        band_gap_ok, cores_busy, converter_on, trigger_hold, err;
   logic        hold_done_irq, shared_manual_sample, sw_channel_trigger;
   logic        sw_level_common_trigger, sw_pulse_common_trigger;
   logic        shared_core_enable;
   logic [10:0] shared_sample_cycles;
   logic [2:0]  reference_select;
   logic [5:0]  sw_channel_number, conv_clock_divider;
   logic [1:0]  conv_clock_source;
   logic [6:0]  core_source_div_count;
   logic [3:0]  dedicated_core_enable;
   logic [9:0]  sv [3] = '{10'h3FF, 10'h001, 10'h000};
   int          n_mismatch = 0, checks = 0, cyc = 0, c;
   int          n_ch = 0, n_pu = 0, n_irq = 0;
   acc_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .band_gap_ok, .cores_busy, .converter_on,
      .shared_sample_cycles, .reference_select, .trigger_hold, .hold_done_irq,
      .shared_manual_sample, .sw_channel_trigger, .sw_level_common_trigger,
      .sw_pulse_common_trigger, .sw_channel_number, .conv_clock_source,
      .conv_clock_divider, .core_source_div_count, .shared_core_enable,
      .dedicated_core_enable);
   task automatic close_out;
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // The request is held until pready is seen high, however long that is.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Pulses are counted every cycle so that none slips between reads.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sw_channel_trigger === 1'b1) n_ch <= n_ch + 1;
      if (sw_pulse_common_trigger === 1'b1) n_pu <= n_pu + 1;
      if (hold_done_irq === 1'b1) n_irq <= n_irq + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, band_gap_ok, cores_busy} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk("reset", rd, 32'h0000_0000);
      end
      foreach (sv[i]) begin
         apb(1'b1, OFS_REF_STATUS, {22'h0, sv[i]} | 32'hFFFF_FC00);
         apb(1'b0, OFS_REF_STATUS, 32'h0);
         chk("samt", rd, {22'h0, sv[i]});
         chk("samt cyc", {21'h0, shared_sample_cycles}, {22'h0, sv[i]} + 2);
      end
      band_gap_ok <= 1'b1;
      apb(1'b1, OFS_CONV_ON, 32'h1);
      chk("conv on", {31'h0, converter_on}, 32'h1);
      apb(1'b0, OFS_REF_STATUS, 32'h0);
      chk("ready", rd, 32'h0000_8000);
      band_gap_ok <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, OFS_REF_STATUS, 32'h0);
      chk("ref err", rd, 32'h0000_4000);
      apb(1'b1, OFS_CONV_ON, 32'h0);
      apb(1'b0, OFS_REF_STATUS, 32'h0);
      chk("err clr", rd, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         v = {16'h0, 2'(i), 6'(i * 21), i[0], 3'h7, 4'(1 << i)};
         apb(1'b1, OFS_CLK_EN, v);
         apb(1'b0, OFS_CLK_EN, 32'h0);
         chk("clk reg", rd, v & 32'h0000_FF8F);
         chk("div", {26'h0, conv_clock_divider}, 32'(i * 21));
         got = {18'h0, conv_clock_source, core_source_div_count,
                shared_core_enable, dedicated_core_enable};
         chk("clk out", got, {18'h0, v[15:14], 7'(i * 21 + 1), v[7], v[3:0]});
      end
      c = n_ch;
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_012A);
      apb(1'b0, OFS_TRIG_CTRL, 32'h0);
      chk("ch trig", 32'(n_ch - c), 32'h1);
      chk("ch rd", rd, 32'h0000_002A);
      chk("ch num", {26'h0, sw_channel_number}, 32'h0000_002A);
      c = n_pu;
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_0040);
      apb(1'b0, OFS_TRIG_CTRL, 32'h0);
      chk("pulse", 32'(n_pu - c), 32'h1);
      chk("pulse rd", rd, 32'h0000_0000);
      chk("ref sel", {29'h0, reference_select}, 32'h0);
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_0285);
      apb(1'b0, OFS_TRIG_CTRL, 32'h0);
      got = {24'h0, sw_level_common_trigger, shared_manual_sample,
             sw_channel_number};
      chk("level", got, 32'h0000_00C5);
      cores_busy <= 1'b1;
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_1C00);
      apb(1'b0, OFS_TRIG_CTRL, 32'h0);
      chk("busy", rd, 32'h0000_1800);
      chk("hold", {31'h0, trigger_hold}, 32'h1);
      c = n_irq;
      cores_busy <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("irq", 32'(n_irq - c), 32'h1);
      c = n_ch + n_pu;
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_1940);
      apb(1'b0, OFS_TRIG_CTRL, 32'h0);
      chk("held", 32'(n_ch + n_pu - c), 32'h0);
      chk("done", rd, 32'h0000_1C00);
      apb(1'b1, OFS_TRIG_CTRL, 32'h0);
      c = n_irq;
      apb(1'b1, OFS_TRIG_CTRL, 32'h0000_1000);
      repeat (10) @(posedge pclk);
      chk("no irq", 32'(n_irq - c), 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("unmapped", rd, 32'h0);
      close_out();
   end
endmodule : tb
`default_nettype wire
